// ==== pkg/serial_line_pkg.sv ====
// Shared constants for the serial line control and status block
package serial_line_pkg;
	// ==========================================================
	// Register offsets (three address bits)
	localparam logic [2:0] OFS_DATA   = 3'h0;
	localparam logic [2:0] OFS_IRQ_EN = 3'h1;
	localparam logic [2:0] OFS_IRQ_ID = 3'h2;
	localparam logic [2:0] OFS_LCR    = 3'h3;
	localparam logic [2:0] OFS_MCR    = 3'h4;
	localparam logic [2:0] OFS_LSR    = 3'h5;
	localparam logic [2:0] OFS_MSR    = 3'h6;
	localparam logic [2:0] OFS_SCRATCH = 3'h7;
	// ==========================================================
	// Line control field positions
	localparam int LCR_STOP  = 2;
	localparam int LCR_PAR   = 3;
	localparam int LCR_EVEN  = 4;
	localparam int LCR_STICK = 5;
	localparam int LCR_BREAK = 6;
	localparam int LCR_DIVISOR_ACCESS_SEL  = 7;
	// Modem control field positions
	localparam int MCR_LOOP  = 4;
	// Interrupt enable field positions
	localparam int IER_RDA  = 0;
	localparam int IER_TX_HOLDING_EMPTY = 1;
	localparam int IER_RLS  = 2;
	localparam int IER_MS   = 3;
	// ==========================================================
	// Interrupt identification codes
	localparam logic [7:0] IID_NONE = 8'h01;
	localparam logic [7:0] IID_RLS  = 8'h06;
	localparam logic [7:0] IID_RDA  = 8'h04;
	localparam logic [7:0] IID_TX_HOLDING_EMPTY = 8'h02;
	localparam logic [7:0] IID_MS   = 8'h00;
	// ==========================================================
	// Reset values
	localparam logic [7:0]  LCR_RESET = 8'h00;
	localparam logic [7:0]  LSR_RESET = 8'h60;
	localparam logic [15:0] DIV_RESET = 16'h0000;
	// ==========================================================
	// Timing in 16x ticks
	localparam logic [4:0] TICKS_BIT  = 5'h10;
	localparam logic [4:0] TICKS_HALF = 5'h08;
	localparam logic [4:0] TICKS_1P5  = 5'h18;
	localparam logic [4:0] TICKS_2    = 5'h20;
	localparam int         FIFO_DEPTH = 16;
endpackage : serial_line_pkg

// ==== core/rx_char_fifo.sv ====
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/10ps
module rx_char_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic             flush,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("rx_char_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;

	// Full when pointers differ only in the wrap bit
	assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = mem[rd_ptr[AW-1:0]];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointer update; flush empties without touching storage
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else if (flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end

	// Storage has no reset
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
endmodule : rx_char_fifo

// ==== core/baud_divider.sv ====
// Divides the reference clock by the divisor latch value
`timescale 1ns/10ps
module baud_divider #(
	parameter int DW = 16
) (
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rst_b,
	// Divisor and outputs
	input  wire logic [DW-1:0] divisor,
	output logic               tick,
	output logic               baud_clk_n
);
	initial
	begin
		if (DW < 2)
			$error("baud_divider: DW must be at least 2");
	end

	logic [DW-1:0] count;

	// Count down; a zero divisor stops the clock
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			count      <= '0;
			tick       <= 1'b0;
			baud_clk_n <= 1'b1;
		end
		else
		begin
			tick <= 1'b0;
			if (divisor == '0)
			begin
				count      <= '0;
				baud_clk_n <= 1'b1;
			end
			else if (count <= {{(DW-1){1'b0}}, 1'b1})
			begin
				count      <= divisor;
				tick       <= 1'b1;
				baud_clk_n <= 1'b0;
			end
			else
			begin
				count <= count - 1'b1;
				// Look at the next count so that a divisor of two still toggles
				if (count - 1'b1 <= {1'b0, divisor[DW-1:1]})
					baud_clk_n <= 1'b1;
			end
		end
	end
endmodule : baud_divider

// ==== core/serial_line_ctrl.sv ====
// Serial line element: framing, line status, modem outputs and pins
`timescale 1ns/10ps
module serial_line_ctrl
	import serial_line_pkg::*;
#(
	parameter int DIV_W = 16
) (
	// Clock and resets
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       master_reset,
	// Processor side
	input  wire logic       select_in_a,
	input  wire logic       select_in_b,
	input  wire logic       select_in_c_n,
	input  wire logic [2:0] reg_addr,
	input  wire logic       rd_strobe,
	input  wire logic       wr_strobe,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] rd_data,
	output logic            select_indication,
	output logic            transceiver_disable,
	output logic            irq_out,
	// Serial and clock pins
	input  wire logic       serial_rx_line,
	input  wire logic       rx_clk_16x,
	output logic            serial_tx_line,
	output logic            baud_clk_n,
	// Modem pins
	input  wire logic       clear_send_n,
	input  wire logic       set_ready_n,
	input  wire logic       ring_n,
	input  wire logic       carrier_n,
	output logic            term_ready_n,
	output logic            req_send_n,
	output logic            user_out1_n,
	output logic            user_out2_n
);
	import serial_line_pkg::*;

	initial
	begin
		if (DIV_W != 16)
			$error("serial_line_ctrl: divisor is two byte latches");
	end

	// ==========================================================
	// State
	typedef enum logic [4:0] {
		TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
		TX_PAR = 5'h08, TX_STOP = 5'h10
	} tx_e;
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
		RX_PAR = 5'h08, RX_STOP = 5'h10
	} rx_e;
	typedef struct packed {
		logic [7:0]       lcr;
		logic [4:0]       mcr;
		logic [3:0]       irq_enable_reg;
		logic [7:0]       scratch;
		logic [DIV_W-1:0] div;
		logic [7:0]       tx_holding_reg;
		logic             thr_full;
		logic             tx_holding_empty_irq;
		logic [7:0]       rbr;
		logic             dr;
		logic             oe;
		logic             pe;
		logic             fe;
		logic             bi;
		logic [3:0]       msr_prev;
		logic [3:0]       msr_delta;
		logic             rd_q;
		logic             wr_q;
		logic             rclk_q;
		logic [7:0]       rdata;
		logic             irq;
		tx_e              tx_state;
		logic [7:0]       tx_shift;
		logic [4:0]       tx_cnt;
		logic [3:0]       tx_bit;
		logic             tx_par;
		logic             tx_low;
		logic             line_low;
		rx_e              rx_state;
		logic [3:0]       rx_cnt;
		logic [3:0]       rx_bit;
		logic [7:0]       rx_shift;
		logic             rx_par;
		logic [8:0]       brk_cnt;
		logic             brk_seen;
	} state_s;

	state_s s;
	state_s next_s;

	// ==========================================================
	// Helper functions
	function automatic logic [3:0] char_bits(input logic [7:0] lcr);
		char_bits = {2'b00, lcr[1:0]} + 4'h5;
	endfunction : char_bits

	function automatic logic [4:0] stop_ticks(input logic [7:0] lcr);
		if (!lcr[LCR_STOP])
			stop_ticks = TICKS_BIT;
		else if (lcr[1:0] == 2'b00)
			stop_ticks = TICKS_1P5;
		else
			stop_ticks = TICKS_2;
	endfunction : stop_ticks

	// Parity bit for the low data bits of a character
	function automatic logic par_bit(input logic [7:0] lcr, input logic [7:0] d);
		logic [7:0] mask;
		mask = 8'hff >> (4'h8 - char_bits(lcr));
		if (lcr[LCR_STICK])
			par_bit = !lcr[LCR_EVEN];
		else
			par_bit = lcr[LCR_EVEN] ? ^(d & mask) : !(^(d & mask));
	endfunction : par_bit

	// Whole character time in 16x ticks
	function automatic logic [8:0] frame_ticks(input logic [7:0] lcr);
		logic [8:0] bits;
		bits = {5'h00, char_bits(lcr)} + 9'h001 + {8'h00, lcr[LCR_PAR]};
		frame_ticks = {bits[4:0], 4'h0} + {4'h0, stop_ticks(lcr)};
	endfunction : frame_ticks

	// ==========================================================
	// Submodules
	logic       tx_tick;
	logic       push_valid;
	logic       push_ready;
	logic [7:0] push_data;
	logic       pop_valid;
	logic [7:0] pop_data;

	baud_divider #(.DW(DIV_W)) u_baud (
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.divisor    (s.div),
		.tick       (tx_tick),
		.baud_clk_n (baud_clk_n)
	);

	// Received characters queue here; it drains only into an empty buffer
	rx_char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.flush     (master_reset),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_data),
		.out_valid (pop_valid),
		.out_ready (!s.dr),
		.out_data  (pop_data)
	);

	// ==========================================================
	// Combinational decode
	logic       sel;
	logic       rd_rise;
	logic       wr_rise;
	logic       divisor_access_sel;
	logic       loop;
	logic       rx_tick;
	logic       rx_in;
	logic [3:0] msr_now;
	logic       tx_all_empty;
	logic [7:0] lsr;
	logic [7:0] iid;

	assign sel     = select_in_a & select_in_b & !select_in_c_n;
	assign rd_rise = sel & rd_strobe & !s.rd_q;
	assign wr_rise = sel & wr_strobe & !s.wr_q;
	assign divisor_access_sel    = s.lcr[LCR_DIVISOR_ACCESS_SEL];
	assign loop    = s.mcr[MCR_LOOP];
	assign rx_tick = rx_clk_16x & !s.rclk_q;
	assign rx_in   = loop ? !s.tx_low : serial_rx_line;
	// Loopback feeds the control bits back as the modem inputs
	assign msr_now = loop ? {s.mcr[3], s.mcr[2], s.mcr[0], s.mcr[1]}
		: {!carrier_n, !ring_n, !set_ready_n, !clear_send_n};
	assign tx_all_empty = !s.thr_full && s.tx_state == TX_IDLE;
	assign lsr  = {1'b0, tx_all_empty, !s.thr_full, s.bi, s.fe, s.pe, s.oe, s.dr};

	// Priority: line status, data, holding empty, modem
	always_comb
	begin
		if (s.irq_enable_reg[IER_RLS] && (s.oe | s.pe | s.fe | s.bi))
			iid = IID_RLS;
		else if (s.irq_enable_reg[IER_RDA] && s.dr)
			iid = IID_RDA;
		else if (s.irq_enable_reg[IER_TX_HOLDING_EMPTY] && s.tx_holding_empty_irq)
			iid = IID_TX_HOLDING_EMPTY;
		else if (s.irq_enable_reg[IER_MS] && s.msr_delta != 4'h0)
			iid = IID_MS;
		else
			iid = IID_NONE;
	end

	// Character leaves the receiver at the stop-bit centre
	assign push_valid = rx_tick && s.rx_state == RX_STOP && s.rx_cnt == 4'hf;
	assign push_data  = s.rx_shift >> (4'h8 - char_bits(s.lcr));

	// Pins
	assign select_indication   = sel;
	assign transceiver_disable = !(sel & rd_strobe);
	assign irq_out             = s.irq;
	assign rd_data             = s.rdata;
	assign serial_tx_line      = !s.line_low;
	// Loopback and reset both leave these high
	assign term_ready_n = !(s.mcr[0] & !loop);
	assign req_send_n   = !(s.mcr[1] & !loop);
	assign user_out1_n  = !(s.mcr[2] & !loop);
	assign user_out2_n  = !(s.mcr[3] & !loop);

	// ==========================================================
	// Next state: clears first so that hardware sets win
	always_comb
	begin
		next_s        = s;
		next_s.rd_q   = sel & rd_strobe;
		next_s.wr_q   = sel & wr_strobe;
		next_s.rclk_q = rx_clk_16x;

		// Read side effects
		if (rd_rise)
		begin
			unique case (reg_addr)
				OFS_DATA: if (!divisor_access_sel) next_s.dr = 1'b0;
				OFS_IRQ_ID: if (iid == IID_TX_HOLDING_EMPTY) next_s.tx_holding_empty_irq = 1'b0;
				OFS_LSR:
				begin
					next_s.oe = 1'b0;
					next_s.pe = 1'b0;
					next_s.fe = 1'b0;
					next_s.bi = 1'b0;
				end
				OFS_MSR: next_s.msr_delta = 4'h0;
				default: ;
			endcase
		end
		if (wr_rise && reg_addr == OFS_LSR && !wr_data[0])
			next_s.dr = 1'b0;

		// Modem change detection; ring counts only trailing edge
		next_s.msr_prev = msr_now;
		next_s.msr_delta = next_s.msr_delta
			| ((msr_now ^ s.msr_prev) & 4'hb)
			| {1'b0, s.msr_prev[2] & !msr_now[2], 2'b00};

		// Buffer refill from the queue
		if (pop_valid && !s.dr)
		begin
			next_s.rbr = pop_data;
			next_s.dr  = 1'b1;
		end

		// Receiver, paced by the 16x receive clock
		if (rx_tick)
		begin
			next_s.rx_cnt = s.rx_cnt + 4'h1;
			unique case (s.rx_state)
				RX_IDLE:
				begin
					next_s.rx_cnt = 4'h0;
					if (!rx_in)
						next_s.rx_state = RX_START;
				end
				RX_START:
					if (s.rx_cnt == TICKS_HALF[3:0] - 4'h1)
					begin
						next_s.rx_cnt   = 4'h0;
						next_s.rx_bit   = 4'h0;
						// A start that is gone by mid-bit was noise
						next_s.rx_state = rx_in ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (s.rx_cnt == 4'hf)
					begin
						next_s.rx_shift = {rx_in, s.rx_shift[7:1]};
						next_s.rx_bit   = s.rx_bit + 4'h1;
						if (s.rx_bit == char_bits(s.lcr) - 4'h1)
							next_s.rx_state = s.lcr[LCR_PAR] ? RX_PAR : RX_STOP;
					end
				RX_PAR:
					if (s.rx_cnt == 4'hf)
					begin
						next_s.rx_par   = rx_in;
						next_s.rx_state = RX_STOP;
					end
				RX_STOP:
					if (s.rx_cnt == 4'hf)
					begin
						// Only the first stop bit is checked
						if (!rx_in)
							next_s.fe = 1'b1;
						if (s.lcr[LCR_PAR] && s.rx_par != par_bit(s.lcr, push_data))
							next_s.pe = 1'b1;
						if (!push_ready)
							next_s.oe = 1'b1;
						next_s.rx_state = RX_IDLE;
					end
			endcase

			// Break: spacing for longer than one character
			if (rx_in)
			begin
				next_s.brk_cnt  = 9'h000;
				next_s.brk_seen = 1'b0;
			end
			else if (!s.brk_seen)
			begin
				next_s.brk_cnt = s.brk_cnt + 9'h001;
				if (s.brk_cnt == frame_ticks(s.lcr))
				begin
					next_s.bi       = 1'b1;
					next_s.brk_seen = 1'b1;
				end
			end
		end

		// Transmitter, paced by the baud divider
		if (tx_tick)
		begin
			next_s.tx_cnt = s.tx_cnt + 5'h01;
			unique case (s.tx_state)
				TX_IDLE:
				begin
					next_s.tx_cnt = 5'h00;
					if (s.thr_full)
					begin
						next_s.tx_shift = s.tx_holding_reg;
						next_s.tx_par   = par_bit(s.lcr, s.tx_holding_reg);
						next_s.thr_full = 1'b0;
						next_s.tx_holding_empty_irq = 1'b1;
						next_s.tx_low   = 1'b1;
						next_s.tx_state = TX_START;
					end
				end
				TX_START:
					if (s.tx_cnt == TICKS_BIT - 5'h01)
					begin
						next_s.tx_cnt   = 5'h00;
						next_s.tx_bit   = 4'h0;
						next_s.tx_low   = !s.tx_shift[0];
						next_s.tx_state = TX_DATA;
					end
				TX_DATA:
					if (s.tx_cnt == TICKS_BIT - 5'h01)
					begin
						next_s.tx_cnt = 5'h00;
						next_s.tx_bit = s.tx_bit + 4'h1;
						next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
						if (s.tx_bit != char_bits(s.lcr) - 4'h1)
							next_s.tx_low = !s.tx_shift[1];
						else if (s.lcr[LCR_PAR])
						begin
							next_s.tx_low   = !s.tx_par;
							next_s.tx_state = TX_PAR;
						end
						else
						begin
							next_s.tx_low   = 1'b0;
							next_s.tx_state = TX_STOP;
						end
					end
				TX_PAR:
					if (s.tx_cnt == TICKS_BIT - 5'h01)
					begin
						next_s.tx_cnt   = 5'h00;
						next_s.tx_low   = 1'b0;
						next_s.tx_state = TX_STOP;
					end
				TX_STOP:
					if (s.tx_cnt == stop_ticks(s.lcr) - 5'h01)
						next_s.tx_state = TX_IDLE;
			endcase
		end

		// Register writes; a new character supersedes a shift load
		if (wr_rise)
		begin
			unique case (reg_addr)
				OFS_DATA:
					if (divisor_access_sel)
						next_s.div[7:0] = wr_data;
					else
					begin
						next_s.tx_holding_reg      = wr_data;
						next_s.thr_full = 1'b1;
						next_s.tx_holding_empty_irq = 1'b0;
					end
				OFS_IRQ_EN:
					if (divisor_access_sel)
						next_s.div[15:8] = wr_data;
					else
						next_s.irq_enable_reg = wr_data[3:0];
				OFS_LCR: next_s.lcr = wr_data;
				OFS_MCR: next_s.mcr = wr_data[4:0];
				OFS_SCRATCH: next_s.scratch = wr_data;
				default: ;
			endcase
		end

		// Line drive: break spaces, loopback marks, else shifter
		next_s.line_low = s.lcr[LCR_BREAK] | (!loop & next_s.tx_low);

		// Read data registered from the current decode
		unique case (reg_addr)
			OFS_DATA: next_s.rdata = divisor_access_sel ? s.div[7:0] : s.rbr;
			OFS_IRQ_EN: next_s.rdata = divisor_access_sel ? s.div[15:8] : {4'h0, s.irq_enable_reg};
			OFS_IRQ_ID: next_s.rdata = iid;
			OFS_LCR: next_s.rdata = s.lcr;
			OFS_MCR: next_s.rdata = {3'h0, s.mcr};
			OFS_LSR: next_s.rdata = lsr;
			OFS_MSR: next_s.rdata = {msr_now, s.msr_delta};
			OFS_SCRATCH: next_s.rdata = s.scratch;
		endcase

		next_s.irq = iid != IID_NONE;

		// Master reset keeps divisor, holding and receive buffers
		if (master_reset)
		begin
			next_s          = '0;
			next_s.div      = s.div;
			next_s.tx_holding_reg      = s.tx_holding_reg;
			next_s.rbr      = s.rbr;
			next_s.rdata    = s.rdata;
			next_s.tx_state = TX_IDLE;
			next_s.rx_state = RX_IDLE;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s          <= '0;
			s.tx_state <= TX_IDLE;
			s.rx_state <= RX_IDLE;
		end
		else
			s <= next_s;
	end
endmodule : serial_line_ctrl

// ==== sim/serial_line_properties.sv ====
// Port checks for the serial line element
`timescale 1ns/10ps
module serial_line_props
	import serial_line_pkg::*;
(
	// Clock and resets
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire logic       master_reset,
	// Processor side
	input wire logic       select_in_a,
	input wire logic       select_in_b,
	input wire logic       select_in_c_n,
	input wire logic [2:0] reg_addr,
	input wire logic       rd_strobe,
	input wire logic       wr_strobe,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	input wire logic       select_indication,
	input wire logic       transceiver_disable,
	input wire logic       irq_out,
	// Pins
	input wire logic       serial_tx_line,
	input wire logic       term_ready_n,
	input wire logic       req_send_n,
	input wire logic       user_out1_n,
	input wire logic       user_out2_n
);
	// ==========================================================
	// Write detection: only the first strobe cycle counts
	logic sel;
	logic wr_q;
	logic take;
	assign sel  = select_in_a && select_in_b && !select_in_c_n;
	assign take = sel && wr_strobe && !wr_q && !master_reset;
	// Last strobe state, so a long strobe is not seen twice
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			wr_q <= 1'h0;
		else
			wr_q <= sel && wr_strobe;
	end
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Assertions
	chk_sel_follow: assert property (select_indication == sel)
		else $error("select indication wrong");
	chk_transceiver_disable_read: assert property (transceiver_disable == !(sel && rd_strobe))
		else $error("transceiver disable wrong");
	chk_dtr_write: assert property (take && reg_addr == OFS_MCR |=>
		term_ready_n == !($past(wr_data[0]) && !$past(wr_data[MCR_LOOP])))
		else $error("terminal ready wrong");
	chk_rts_write: assert property (take && reg_addr == OFS_MCR |=>
		req_send_n == !($past(wr_data[1]) && !$past(wr_data[MCR_LOOP])))
		else $error("request to send wrong");
	chk_user_write: assert property (take && reg_addr == OFS_MCR |=>
		{user_out2_n, user_out1_n} == ~($past(wr_data[3:2]) & {2{!$past(wr_data[MCR_LOOP])}}))
		else $error("user outputs wrong");
	chk_modem_reset: assert property (master_reset |=>
		term_ready_n && req_send_n && user_out1_n && user_out2_n)
		else $error("modem outputs not high after reset");
	chk_tx_mark: assert property (master_reset |=> ##1 serial_tx_line)
		else $error("serial output not marking after reset");
	chk_irq_reset: assert property (master_reset |=> ##1 !irq_out)
		else $error("interrupt not low after reset");
	chk_break_space: assert property (take && reg_addr == OFS_LCR && wr_data[LCR_BREAK]
		|-> ##[1:2] !serial_tx_line)
		else $error("break not spacing");
	chk_lsr_top: assert property ($past(reg_addr) == OFS_LSR |->
		!rd_data[7] && (!rd_data[6] || rd_data[5]))
		else $error("status top bits wrong");
endmodule : serial_line_props

bind serial_line_ctrl serial_line_props u_props (.sys_clk, .rst_b, .master_reset, .select_in_a,
	.select_in_b, .select_in_c_n, .reg_addr, .rd_strobe, .wr_strobe, .wr_data, .rd_data,
	.select_indication, .transceiver_disable, .irq_out, .serial_tx_line, .term_ready_n,
	.req_send_n, .user_out1_n, .user_out2_n);

// ==== sim/serial_peer.sv ====
// Far-end serial device model: sends characters and breaks
`timescale 1ns/10ps
module serial_peer (
	// Clock
	input wire logic sys_clk,
	// Serial side
	output logic     serial_rx_line,
	output logic     rx_clk_16x
);
	logic [1:0] div = 2'h0;
	// Free-running 16x clock, one tick every 4 system cycles
	always @(posedge sys_clk)
		div <= div + 2'h1;
	assign rx_clk_16x = div[1];
	initial serial_rx_line = 1'h1;
	// One bit cell is 16 ticks
	task automatic bit_out(input logic b);
	begin
		serial_rx_line <= b;
		repeat (64) @(posedge sys_clk);
	end
	endtask : bit_out
	// Start, data LSB first, optional parity, one stop, then idle
	task automatic send(input logic [7:0] d, input int nb, input logic pe, pv, sv);
		int i;
	begin
		@(posedge sys_clk);
		bit_out(1'h0);
		for (i = 0; i < nb; i++)
			bit_out(d[i]);
		if (pe)
			bit_out(pv);
		bit_out(sv);
		bit_out(1'h1);
	end
	endtask : send
	// Spacing for n cycles, then back to mark
	task automatic hold_low(input int n);
	begin
		@(posedge sys_clk);
		serial_rx_line <= 1'h0;
		repeat (n) @(posedge sys_clk);
		bit_out(1'h1);
	end
	endtask : hold_low
endmodule : serial_peer

// ==== sim/testbench.sv ====
// Self-checking bench for the serial line element
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
	import serial_line_pkg::*;
	logic sys_clk = 1'h0;
	logic rst_b = 1'h0;
	logic master_reset = 1'h0;
	logic select_in_a = 1'h1;
	logic select_in_b = 1'h1;
	logic select_in_c_n = 1'h0;
	logic [2:0] reg_addr = 3'h0;
	logic rd_strobe = 1'h0;
	logic wr_strobe = 1'h0;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] rd_data;
	logic select_indication, transceiver_disable, irq_out, serial_rx_line, rx_clk_16x;
	logic serial_tx_line, baud_clk_n, term_ready_n, req_send_n, user_out1_n, user_out2_n;
	logic [3:0] mouts;
	int error_cnt = 0;
	int checks_done = 0;
	int cycles = 0;
	assign mouts = {user_out2_n, user_out1_n, req_send_n, term_ready_n};
	always #2.5 sys_clk = ~sys_clk;
	// Modem inputs idle: the status side is not exercised by this bench
	serial_line_ctrl #(.DIV_W(16)) u_dut (.sys_clk, .rst_b, .master_reset, .select_in_a,
		.select_in_b, .select_in_c_n, .reg_addr, .rd_strobe, .wr_strobe, .wr_data, .rd_data,
		.select_indication, .transceiver_disable, .irq_out, .serial_rx_line, .rx_clk_16x,
		.serial_tx_line, .baud_clk_n, .clear_send_n(1'h1), .set_ready_n(1'h1),
		.ring_n(1'h1), .carrier_n(1'h1), .term_ready_n, .req_send_n, .user_out1_n,
		.user_out2_n);
	serial_peer u_peer (.sys_clk, .serial_rx_line, .rx_clk_16x);
	// ==========================================================
	// Bus and timing helpers
	task automatic cyc(input int n);
	begin
		repeat (n) @(posedge sys_clk);
		#1;
	end
	endtask : cyc
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
	begin
		@(posedge sys_clk);
		reg_addr  <= a;
		wr_data   <= d;
		wr_strobe <= 1'h1;
		@(posedge sys_clk);
		wr_strobe <= 1'h0;
	end
	endtask : wr
	// Strobe held two cycles so the pre-clear value is seen
	task automatic rd_exp(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
	begin
		@(posedge sys_clk);
		reg_addr  <= a;
		rd_strobe <= 1'h1;
		cyc(1);
		`CHK(rd_data & m, e)
		`CHK(transceiver_disable, 1'h0)
		@(posedge sys_clk);
		rd_strobe <= 1'h0;
	end
	endtask : rd_exp
	// ==========================================================
	// Scenarios
	task automatic t_modem();
	begin
		wr(OFS_MCR, 8'h0f);
		cyc(1);
		`CHK(mouts, 4'h0)
		wr(OFS_MCR, 8'h05);
		cyc(1);
		`CHK(mouts, 4'ha)
		wr(OFS_MCR, 8'h1f);
		cyc(1);
		`CHK(mouts, 4'hf)
		wr(OFS_MCR, 8'h00);
	end
	endtask : t_modem
	task automatic t_select();
	begin
		select_in_b <= 1'h0;
		cyc(1);
		`CHK(select_indication, 1'h0)
		wr(OFS_LCR, 8'h55);
		select_in_b <= 1'h1;
		cyc(1);
		`CHK(transceiver_disable, 1'h1)
		rd_exp(OFS_LCR, 8'h00, 8'hff);
	end
	endtask : t_select
	// Divisor 2 gives one baud clock fall every 2 cycles
	task automatic t_div();
		int k;
		int n;
		logic prev;
	begin
		wr(OFS_LCR, 8'h83);
		wr(OFS_DATA, 8'h02);
		wr(OFS_IRQ_EN, 8'h00);
		rd_exp(OFS_DATA, 8'h02, 8'hff);
		wr(OFS_LCR, 8'h03);
		for (k = 0; k < 100 && baud_clk_n; k++)
			cyc(1);
		n = 0;
		for (k = 0; k < 40; k++)
		begin
			prev = baud_clk_n;
			cyc(1);
			n += int'(prev && !baud_clk_n);
		end
		`CHK(n, 20)
	end
	endtask : t_div
	// Two chars back to back; bit cell is 32 cycles
	task automatic t_frame(input logic [7:0] lcr, input logic [7:0] d);
		int i;
		int nb;
		int sl;
		logic p;
	begin
		nb = int'(lcr[1:0]) + 5;
		sl = !lcr[2] ? 32 : (nb == 5 ? 48 : 64);
		p  = lcr[5] ? !lcr[4] : (^(d & ~(8'hff << nb))) ^ !lcr[4];
		wr(OFS_LCR, lcr);
		fork
			begin
				for (i = 0; i < 300 && serial_tx_line; i++)
					cyc(1);
				cyc(16);
				`CHK(serial_tx_line, 1'h0)
				for (i = 0; i < nb; i++)
				begin
					cyc(32);
					`CHK(serial_tx_line, d[i])
				end
				if (lcr[3])
				begin
					cyc(32);
					`CHK(serial_tx_line, p)
				end
				cyc(32 + sl - 20);
				`CHK(serial_tx_line, 1'h1)
				cyc(20);
				`CHK(serial_tx_line, 1'h0)
			end
			begin
				wr(OFS_DATA, d);
				wr(OFS_DATA, 8'h00);
				rd_exp(OFS_LSR, 8'h00, 8'h60);
			end
		join
		cyc(450);
		rd_exp(OFS_LSR, 8'h60, 8'hff);
	end
	endtask : t_frame
	// Receive, errors, overrun with buffer and queue both full, then a break
	task automatic t_rx();
		int i;
	begin
		wr(OFS_LCR, 8'h1b);
		wr(OFS_IRQ_EN, 8'h04);
		u_peer.send(8'ha5, 8, 1'h1, 1'h0, 1'h1);
		rd_exp(OFS_LSR, 8'h61, 8'hff);
		rd_exp(OFS_DATA, 8'ha5, 8'hff);
		rd_exp(OFS_LSR, 8'h60, 8'hff);
		u_peer.send(8'h5a, 8, 1'h1, 1'h1, 1'h1);
		`CHK(irq_out, 1'h1)
		rd_exp(OFS_LSR, 8'h65, 8'hff);
		cyc(2);
		`CHK(irq_out, 1'h0)
		wr(OFS_LSR, 8'h00);
		rd_exp(OFS_LSR, 8'h60, 8'hff);
		u_peer.send(8'h80, 8, 1'h1, 1'h1, 1'h0);
		rd_exp(OFS_LSR, 8'h69, 8'hff);
		rd_exp(OFS_LSR, 8'h61, 8'hff);
		rd_exp(OFS_DATA, 8'h80, 8'hff);
		for (i = 0; i < 18; i++)
			u_peer.send(8'(i), 8, 1'h1, ^(8'(i)), 1'h1);
		rd_exp(OFS_LSR, 8'h63, 8'hff);
		rd_exp(OFS_LSR, 8'h61, 8'hff);
		for (i = 0; i < 17; i++)
			rd_exp(OFS_DATA, 8'(i), 8'hff);
		rd_exp(OFS_LSR, 8'h60, 8'hff);
		u_peer.hold_low(64 * 13);
		rd_exp(OFS_LSR, 8'h10, 8'h10);
		rd_exp(OFS_LSR, 8'h00, 8'h1e);
	end
	endtask : t_rx
	task automatic t_break();
	begin
		wr(OFS_LCR, 8'h43);
		cyc(42);
		`CHK(serial_tx_line, 1'h0)
		wr(OFS_LCR, 8'h03);
		cyc(2);
		`CHK(serial_tx_line, 1'h1)
	end
	endtask : t_break
	task automatic t_reset();
	begin
		`CHK(serial_tx_line, 1'h1)
		`CHK(mouts, 4'hf)
		`CHK(irq_out, 1'h0)
		rd_exp(OFS_LCR, 8'h00, 8'hff);
		rd_exp(OFS_LSR, 8'h60, 8'hff);
	end
	endtask : t_reset
	// ==========================================================
	// Verdict and run control
	task automatic stop_test();
	begin
		if (error_cnt == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask : stop_test
	// Run takes about 21000 cycles; ceiling leaves margin
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			error_cnt++;
			stop_test();
		end
	end
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'h1;
		cyc(1);
		t_reset();
		t_modem();
		t_select();
		t_div();
		t_frame(8'h04, 8'h35);
		t_frame(8'h39, 8'h2b);
		t_frame(8'h1a, 8'h35);
		t_frame(8'h0f, 8'hc6);
		t_frame(8'h2a, 8'h51);
		t_break();
		t_rx();
		wr(OFS_MCR, 8'h0f);
		@(posedge sys_clk);
		master_reset <= 1'h1;
		@(posedge sys_clk);
		master_reset <= 1'h0;
		cyc(2);
		t_reset();
		stop_test();
	end
endmodule : testbench
